// File: inc/rtp_pkg.sv
// Constants shared by the temperature telegram packer and its buffer.
package rtp_pkg;
	// Clock rate in Hz and in kHz for the cycle arithmetic.
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
	// Conversion times in milliseconds, without and with line checking.
	localparam int unsigned CONV_FAST_MS = 20;
	localparam int unsigned CONV_SLOW_MS = 125;
	localparam int unsigned CONV_FAST_CYC = CONV_FAST_MS * CLK_KHZ;
	localparam int unsigned CONV_SLOW_CYC = CONV_SLOW_MS * CLK_KHZ;
	// Telegram cadence of 6.5 ms, held in microseconds.
	localparam int unsigned CADENCE_US = 6500;
	localparam int unsigned CADENCE_CYC = (CADENCE_US * (CLK_HZ / 1000000));
	// Word layout.
	localparam int unsigned WORD_W = 16;
	localparam int unsigned STAT_W = 4;
	localparam int unsigned FAULT_BIT = 1;
	localparam int unsigned BYTE_W = 8;
	// Default scaling endpoints that allow status bits.
	localparam logic [15:0] SCALE_LO_DEF = 16'h2710;
	localparam logic [15:0] SCALE_HI_DEF = 16'hC350;
	// Cyclic configuration code, input byte count and output byte count.
	localparam logic [7:0] CFG_CODE = 8'h32;
	localparam logic [1:0] IN_BYTES = 2'h2;
	localparam logic [1:0] OUT_BYTES = 2'h0;
	// Buffer depth in words.
	localparam int unsigned FIFO_DEPTH = 8;
	// Error strategies.
	typedef enum logic [1:0] {
		RTP_ERR_CURRENT,
		RTP_ERR_SUBST,
		RTP_ERR_LAST
	} rtp_err_t;
endpackage

// File: logic/rtp_fifo.sv
// Synchronous word FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module rtp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire do_wr;
	wire do_rd;

	// Full and empty come from the fill count, so they never disagree.
	assign in_ready = (cnt_q != DEPTH_C);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// Storage needs no reset; only the pointers and the fill count carry state.
	always_ff @(posedge clk_sys) begin
		if (do_wr) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_wr) begin
				wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
			end
			if (do_rd) begin
				rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end
endmodule

// File: logic/rtp_packer.sv
// Resistance thermometer channel: conversion pacing, fault handling and telegram packing.
`timescale 1ns/10ps
module rtp_packer #(
	parameter int unsigned CONV_FAST = rtp_pkg::CONV_FAST_CYC,
	parameter int unsigned CONV_SLOW = rtp_pkg::CONV_SLOW_CYC,
	parameter int unsigned CADENCE = rtp_pkg::CADENCE_CYC,
	parameter int unsigned DEPTH = rtp_pkg::FIFO_DEPTH,
	parameter int unsigned DLY_W = 8
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic line_fault_check,
	input wire logic with_status,
	input wire logic [1:0] err_mode,
	input wire logic [15:0] scale_lo,
	input wire logic [15:0] scale_hi,
	input wire logic [15:0] subst_val,
	input wire logic [15:0] filt_step,
	input wire logic [DLY_W-1:0] fault_delay,
	output logic conv_start,
	input wire logic res_valid,
	input wire logic [15:0] res_data,
	input wire logic lead_break,
	input wire logic lead_short,
	output logic tel_valid,
	input wire logic tel_ready,
	output logic [15:0] tel_word,
	output logic [7:0] tel_byte_first,
	output logic [7:0] tel_byte_second,
	output logic diag,
	output logic [7:0] cfg_code,
	output logic [1:0] in_bytes,
	output logic [1:0] out_bytes
);
	localparam int unsigned CW = $clog2(CONV_SLOW + 1);
	localparam int unsigned TW = $clog2(CADENCE + 1);
	localparam logic [CW-1:0] FAST_C = CW'(CONV_FAST - 1);
	localparam logic [CW-1:0] SLOW_C = CW'(CONV_SLOW - 1);
	localparam logic [TW-1:0] CAD_C = TW'(CADENCE - 1);

	logic [CW-1:0] conv_cnt_q;
	logic conv_start_q;
	logic [TW-1:0] cad_cnt_q;
	logic pend_q;
	logic [15:0] filt_q;
	logic filt_init_q;
	logic fault_q;
	logic [DLY_W-1:0] good_cnt_q;
	logic [15:0] last_good_q;
	logic tel_valid_q;
	logic [15:0] tel_word_q;

	wire conv_done;
	wire [CW-1:0] conv_reload;
	wire cad_tick;
	wire [16:0] span;
	wire [32:0] prod;
	wire [15:0] scaled;
	wire [15:0] diff_up;
	wire [15:0] diff_dn;
	wire [15:0] filt_d;
	wire raw_fault;
	wire clean_done;
	wire [15:0] sel_val;
	wire stat_ok;
	wire [15:0] word_d;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [15:0] fifo_out_data;
	wire out_load;
	wire fifo_pop;

	// The conversion period follows the line checking setting; a changed
	// setting takes effect at the next reload, so no period is cut short.
	assign conv_done = (conv_cnt_q == '0);
	assign conv_reload = line_fault_check ? SLOW_C : FAST_C;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			conv_cnt_q <= '0;
			conv_start_q <= 1'b0;
		end else begin
			conv_cnt_q <= conv_done ? conv_reload : conv_cnt_q - 1'b1;
			conv_start_q <= conv_done;
		end
	end

	// Scaling maps the full 16-bit conversion code onto the configured
	// endpoints; the 17-bit span keeps the product exact before the shift.
	assign span = (scale_hi >= scale_lo) ? ({1'b0, scale_hi} - {1'b0, scale_lo}) : 17'h00000;
	assign prod = {17'h00000, res_data} * {16'h0000, span};
	assign scaled = scale_lo + prod[31:16];

	// Ramp filter: each result moves the output by at most filt_step.
	// A step of zero disables it. The first result loads straight through.
	assign diff_up = scaled - filt_q;
	assign diff_dn = filt_q - scaled;
	assign filt_d = (filt_step == 16'h0000) || !filt_init_q ? scaled :
		(scaled > filt_q) ? ((diff_up > filt_step) ? filt_q + filt_step : scaled) :
		((diff_dn > filt_step) ? filt_q - filt_step : scaled);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			filt_q <= '0;
			filt_init_q <= 1'b0;
		end else if (res_valid) begin
			filt_q <= filt_d;
			filt_init_q <= 1'b1;
		end
	end

	// A faulty result sets the fault at once; clearing needs a run of clean
	// results, which stops a loose contact from toggling the status.
	assign raw_fault = line_fault_check && (lead_break || lead_short);
	assign clean_done = (good_cnt_q + 1'b1 >= fault_delay);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fault_q <= 1'b0;
			good_cnt_q <= '0;
		end else if (!line_fault_check) begin
			fault_q <= 1'b0;
			good_cnt_q <= '0;
		end else if (res_valid) begin
			if (raw_fault) begin
				fault_q <= 1'b1;
				good_cnt_q <= '0;
			end else if (fault_q) begin
				if (clean_done) begin
					fault_q <= 1'b0;
					good_cnt_q <= '0;
				end else begin
					good_cnt_q <= good_cnt_q + 1'b1;
				end
			end
		end
	end

	// The last good value only moves while no fault is reported, so it
	// keeps the value from before the fault for the whole fault.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			last_good_q <= '0;
		end else if (res_valid && !raw_fault && !fault_q) begin
			last_good_q <= filt_d;
		end
	end

	// Error strategy picks the value sent while a fault stands.
	assign sel_val = !fault_q ? filt_q :
		(err_mode == rtp_pkg::RTP_ERR_SUBST) ? subst_val :
		(err_mode == rtp_pkg::RTP_ERR_LAST) ? last_good_q : filt_q;

	// Status bits appear only with the default span; otherwise the word
	// carries the full 16-bit value.
	assign stat_ok = with_status && (scale_lo == rtp_pkg::SCALE_LO_DEF) &&
		(scale_hi == rtp_pkg::SCALE_HI_DEF);
	assign word_d = stat_ok ? {sel_val[15:rtp_pkg::STAT_W], 2'b00, fault_q, 1'b0} :
		sel_val;

	// Cadence timer runs free of the conversions. A tick arms a pending
	// push that waits for buffer room, so a full buffer stalls the sender.
	assign cad_tick = (cad_cnt_q == '0);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cad_cnt_q <= CAD_C;
			pend_q <= 1'b0;
		end else begin
			cad_cnt_q <= cad_tick ? CAD_C : cad_cnt_q - 1'b1;
			if (cad_tick) begin
				pend_q <= 1'b1;
			end else if (fifo_in_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	// The word is taken at push time, so between conversions the latest
	// result is repeated.
	rtp_fifo #(
		.WIDTH(rtp_pkg::WORD_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data(word_d),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// Output stage keeps every link output on a flip-flop.
	assign out_load = !tel_valid_q || tel_ready;
	assign fifo_pop = out_load && fifo_out_valid;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tel_valid_q <= 1'b0;
			tel_word_q <= '0;
		end else if (out_load) begin
			tel_valid_q <= fifo_out_valid;
			if (fifo_out_valid) begin
				tel_word_q <= fifo_out_data;
			end
		end
	end

	// Identity of the cyclic image; these are constants held in flops.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_code <= rtp_pkg::CFG_CODE;
			in_bytes <= rtp_pkg::IN_BYTES;
			out_bytes <= rtp_pkg::OUT_BYTES;
		end else begin
			cfg_code <= rtp_pkg::CFG_CODE;
			in_bytes <= rtp_pkg::IN_BYTES;
			out_bytes <= rtp_pkg::OUT_BYTES;
		end
	end

	// The diagnostic mirrors the reported fault.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			diag <= 1'b0;
		end else begin
			diag <= fault_q;
		end
	end

	assign conv_start = conv_start_q;
	assign tel_valid = tel_valid_q;
	assign tel_word = tel_word_q;
	// The status byte is sent first so the value stays one field in the word.
	assign tel_byte_first = tel_word_q[rtp_pkg::BYTE_W-1:0];
	assign tel_byte_second = tel_word_q[rtp_pkg::WORD_W-1:rtp_pkg::BYTE_W];
endmodule

// File: tb/rtp_packer_properties.sv
// Port checker for the temperature telegram packer.
`timescale 1ns/10ps
module rtp_packer_properties #(
	parameter int CONV_FAST = 40,
	parameter int CONV_SLOW = 200
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic line_fault_check,
	input wire logic with_status,
	input wire logic [15:0] scale_lo,
	input wire logic [15:0] scale_hi,
	input wire logic conv_start,
	input wire logic res_valid,
	input wire logic lead_break,
	input wire logic lead_short,
	input wire logic tel_valid,
	input wire logic tel_ready,
	input wire logic [15:0] tel_word,
	input wire logic [7:0] tel_byte_first,
	input wire logic [7:0] tel_byte_second,
	input wire logic diag,
	input wire logic [7:0] cfg_code,
	input wire logic [1:0] in_bytes,
	input wire logic [1:0] out_bytes
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Status layout only holds once the configuration has settled for a few cycles.
	property p_stat; (with_status && scale_lo == 16'h2710 && scale_hi == 16'hC350)[*4] ##0 tel_valid
		|-> tel_word[0] == 1'b0 && tel_word[3:2] == 2'h0; endproperty
	a_stat: assert property (p_stat) else $error("unused status bits set");
	property p_code; cfg_code == 8'h32; endproperty
	a_code: assert property (p_code) else $error("bad configuration code");
	property p_bytes; in_bytes == 2'h2 && out_bytes == 2'h0; endproperty
	a_bytes: assert property (p_bytes) else $error("bad byte counts");
	property p_first; tel_byte_first == tel_word[7:0] && tel_byte_second == tel_word[15:8]; endproperty
	a_first: assert property (p_first) else $error("byte order wrong");
	property p_fast; conv_start && !line_fault_check |-> ##CONV_FAST conv_start; endproperty
	a_fast: assert property (p_fast) else $error("fast conversion period wrong");
	property p_slow; conv_start && line_fault_check |-> ##1 !conv_start ##(CONV_SLOW-1) conv_start;
	endproperty
	a_slow: assert property (p_slow) else $error("slow conversion period wrong");
	property p_hold; tel_valid && !tel_ready |=> tel_valid && $stable(tel_word); endproperty
	a_hold: assert property (p_hold) else $error("telegram dropped before taken");
	property p_diag; res_valid && line_fault_check && (lead_break || lead_short) |-> ##2 diag;
	endproperty
	a_diag: assert property (p_diag) else $error("fault not reported");
	property p_off; (!line_fault_check)[*3] |-> !diag; endproperty
	a_off: assert property (p_off) else $error("fault reported while checking off");
endmodule
bind rtp_packer rtp_packer_properties #(.CONV_FAST(CONV_FAST), .CONV_SLOW(CONV_SLOW)) chk (.*);

// File: tb/rtp_comm_model.sv
// Communication unit model that takes telegrams from the packer.
`timescale 1ns/10ps
module rtp_comm_model #(
	parameter logic [7:0] CFG = 8'h32
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic stall,
	input wire logic tel_valid,
	input wire logic [15:0] tel_word,
	input wire logic [7:0] cfg_code,
	output logic tel_ready,
	output logic cfg_ok
);
	logic [15:0] got [$];
	// Stall follows the bench's off-edge drive, so ready never moves on a sampling edge.
	assign tel_ready = resetn & !stall;
	// cfg_ok flags whether the layout code matches the device's; words are taken whether or not it matches.
	assign cfg_ok = (cfg_code === CFG);
	// Every word taken is kept in arrival order.
	always @(posedge clk_sys) begin
		if (resetn && tel_valid && tel_ready) begin
			got.push_back(tel_word);
		end
	end
endmodule

// File: tb/rtp_packer_tb.sv
// Self-checking testbench for the temperature telegram packer.
`timescale 1ns/10ps
module rtp_packer_tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic line_fault_check = 1'b0, with_status = 1'b1, res_valid = 1'b0, lead_break = 1'b0;
	logic lead_short = 1'b0;
	logic stall = 1'b0, tel_valid, tel_ready, conv_start, diag, cfg_ok;
	logic [1:0] err_mode = 2'h0, in_bytes, out_bytes;
	logic [15:0] scale_lo = 16'h2710, scale_hi = 16'hC350, subst_val = 16'h1234;
	logic [15:0] filt_step = 16'h0000, res_data = 16'h0000, tel_word, w;
	logic [7:0] fault_delay = 8'h03, cfg_code;
	int err_count = 0;
	int compares = 0;
	always #25 clk_sys = ~clk_sys;
	rtp_packer #(.CONV_FAST(40), .CONV_SLOW(200), .CADENCE(13)) dut (.clk_sys(clk_sys),
		.resetn(resetn), .line_fault_check(line_fault_check), .with_status(with_status),
		.err_mode(err_mode), .scale_lo(scale_lo), .scale_hi(scale_hi), .subst_val(subst_val),
		.filt_step(filt_step), .fault_delay(fault_delay), .conv_start(conv_start),
		.res_valid(res_valid), .res_data(res_data), .lead_break(lead_break),
		.lead_short(lead_short),
		.tel_valid(tel_valid), .tel_ready(tel_ready), .tel_word(tel_word), .tel_byte_first(),
		.tel_byte_second(), .diag(diag), .cfg_code(cfg_code), .in_bytes(in_bytes),
		.out_bytes(out_bytes));
	rtp_comm_model m (.clk_sys(clk_sys), .resetn(resetn), .stall(stall), .tel_valid(tel_valid),
		.tel_word(tel_word), .cfg_code(cfg_code), .tel_ready(tel_ready), .cfg_ok(cfg_ok));
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One result pulse, then time for the fault flag to settle.
	task automatic send(input logic [15:0] d, input logic b);
		res_valid = 1'b1;
		res_data = d;
		lead_break = b;
		@(posedge clk_sys);
		#1;
		res_valid = 1'b0;
		lead_break = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// Skip stale words, then take the next fresh telegram within a bounded wait.
	task automatic word(output logic [15:0] v);
		int n = 0;
		repeat (30) @(posedge clk_sys);
		m.got.delete();
		while (m.got.size() == 0 && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
		#1;
		if (m.got.size() == 0) begin
			err_count++;
			$display("Error telegram wait expected word seen none");
			close_out();
		end else begin
			v = m.got[0];
		end
	endtask
	task automatic t_layout();
		chk("cfg_ok", 16'h0001, {15'h0, cfg_ok});
		send(16'h8000, 1'b0);
		word(w); chk("word status", 16'h7530, w);
		word(w); chk("word repeat", 16'h7530, w);
		with_status = 1'b0;
		send(16'hFFFF, 1'b0);
		word(w); chk("word plain", 16'hC34F, w);
		with_status = 1'b1;
		scale_lo = 16'h0000;
		scale_hi = 16'hFFFF;
		send(16'hFFFF, 1'b0);
		word(w); chk("word rescaled", 16'hFFFE, w);
		scale_lo = 16'h2710;
		scale_hi = 16'hC350;
	endtask
	task automatic t_fault();
		line_fault_check = 1'b1;
		send(16'h8000, 1'b0);
		send(16'hFFFF, 1'b1);
		chk("diag", 16'h0001, {15'h0, diag});
		word(w); chk("word current", 16'hC342, w);
		err_mode = 2'h1;
		word(w); chk("word subst", 16'h1232, w);
		err_mode = 2'h2;
		word(w); chk("word last", 16'h7532, w);
		// A short circuit keeps the fault standing just as a break does.
		lead_short = 1'b1;
		send(16'h4000, 1'b0);
		lead_short = 1'b0;
		chk("diag short", 16'h0001, {15'h0, diag});
		for (int i = 0; i < 3; i++) begin
			send(16'h4000, 1'b0);
			chk("diag clear", (i == 2) ? 16'h0000 : 16'h0001, {15'h0, diag});
		end
		word(w); chk("word clean", 16'h4E20, w);
		line_fault_check = 1'b0;
		send(16'h4000, 1'b1);
		chk("diag off", 16'h0000, {15'h0, diag});
		word(w); chk("word off", 16'h4E20, w);
	endtask
	task automatic t_filter();
		filt_step = 16'h0100;
		send(16'h8000, 1'b0);
		word(w); chk("word ramp", 16'h4F20, w);
		filt_step = 16'h0000;
	endtask
	// The far side refuses for many cadences, so the buffer fills and then drains.
	task automatic t_fifo();
		stall = 1'b1;
		repeat (156) @(posedge clk_sys);
		#1;
		chk("valid stalled", 16'h0001, {15'h0, tel_valid});
		m.got.delete();
		stall = 1'b0;
		repeat (12) @(posedge clk_sys);
		#1;
		chk("drained", 16'h0001, {15'h0, m.got.size() >= 8});
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		t_layout();
		t_fault();
		t_filter();
		t_fifo();
		close_out();
	end
endmodule
